// ---- rtl/aopc_pkg.sv ----
/*
 Package for the output, synthesiser and pattern control register bank.
 Assumes a byte-wide register space behind a 32-bit Avalon-MM slave.
*/
package aopc_pkg;
    // Register indices; the bus byte address is the index times four
    localparam logic [9:0] OFFS_HI_IDX = 10'h067;
    localparam logic [9:0] FLAG_IDX = 10'h068;
    localparam logic [9:0] RECAL_IDX = 10'h06B;
    localparam logic [9:0] CKDLY_IDX = 10'h06D;
    localparam logic [9:0] PATA_IDX = 10'h074;
    localparam logic [9:0] OFFS_LO_IDX = 10'h066;
    localparam logic [9:0] PATA_HI_IDX = 10'h075;
    localparam logic [9:0] SRCCFG_IDX = 10'h0E0;
    localparam logic [9:0] STATUS_IDX = 10'h0D1;

    localparam logic [7:0] OFFS_HI_RST = 8'h00;
    localparam logic [7:0] FLAG_RST = 8'h24;
    localparam logic [7:0] RECAL_RST = 8'h08;
    localparam logic [7:0] CKDLY_RST = 8'h00;
    localparam logic [7:0] PATA_RST = 8'h00;
    localparam logic [7:0] SRCCFG_RST = 8'h00;

    localparam int FLAG_EN_BIT = 2;
    localparam int FLAG_POL_BIT = 3;
    localparam int RECAL_BIT = 2;
    localparam int PLLCLK_BIT = 5;
    localparam int DLY_LSB = 1;
    localparam logic [7:0] CKDLY_WMASK = 8'h3F;
    localparam int SRC_PLL_BIT = 0;
    localparam int SRC_PLLEN_BIT = 1;
    localparam int SRC_DEC_BIT = 2;
    localparam int CAL_CYCLES = 16;

    typedef struct packed {
        logic [15:0] offset;
        logic [11:0] pattern;
        logic [2:0] delay;
        logic flagEn;
        logic flagPol;
        logic pllClkEn;
    } aopc_cfg_s;
endpackage : aopc_pkg

// ---- rtl/aopc_regs.sv ----
/*
 Register bank: offset correction, flag pair, synthesiser recalibration,
 output clock delay and pattern A. Assumes a synchronous Avalon-MM master
 on clk and ADC samples arriving on clk as well.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Offset high byte is writable, resets to zero.
// - Sixteen-bit signed offset, quarter-LSB steps, is added to each sample.
// - Overrange/word-clock pair driven only while enable bit 2 is one; resets one.
// - Any change of the recalibration toggle starts a calibration.
// - Calibration progress appears in a separate status register.
// - Synthesiser clock reaches the core only while its enable bit is one.
// - Three-bit field delays output clock by 0,1,...,5,14,15 VCO cycles.
// - Delay applies only with synthesiser source and no decimation.
// - Clock delay register is ignored unless synthesiser selected and enabled.
// - Pattern A low nibble sits in bits 7..4 of its register.
// - Clock delay register bits 7..6 read zero, ignore writes.
module aopc_regs #(
    parameter int SAMPLE_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [SAMPLE_W-1:0] sampleIn,
    input wire logic overrangeIn,
    input wire logic wordClockIn,
    input wire logic synthClkGate,
    output logic [SAMPLE_W-1:0] sampleOut,
    output logic overrange_flag,
    output logic word_clock_marker,
    output logic coreClkEnable,
    output logic [3:0] outputClockVcoDelay,
    output logic recalStart,
    output logic [11:0] patternA
);
    // Sum needs headroom above the quarter-LSB sample and the full offset
    if (SAMPLE_W < 4 || SAMPLE_W > 15)
    begin : g_bad_sample_w
        $error("SAMPLE_W out of range");
    end

    logic rstMeta, rstSync;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    logic [7:0] offsHi_reg, offsLo_reg, flag_reg, recal_reg, ckdly_reg;
    logic [7:0] pataLo_reg, pataHi_reg, srccfg_reg;
    logic recalPrev_reg;
    logic [4:0] calCnt_reg;
    logic [SAMPLE_W-1:0] sample_reg;
    logic ovr_reg, wck_reg, coreEn_reg, start_reg, wait_reg;
    logic [3:0] dly_reg;
    logic [31:0] rdata_reg;

    // Access completes on second cycle; waitrequest high first cycle
    wire logic access = (read | write) & wait_reg;
    wire logic wrEn = write & ~wait_reg & byteenable[0];
    wire logic [7:0] wd = writedata[7:0];
    wire logic synthActive = srccfg_reg[aopc_pkg::SRC_PLL_BIT]
        & srccfg_reg[aopc_pkg::SRC_PLLEN_BIT];
    wire logic calBusy = calCnt_reg != 5'h00;
    wire logic toggled = recal_reg[aopc_pkg::RECAL_BIT] ^ recalPrev_reg;

    function automatic logic [7:0] rd_mux(input logic [9:0] a);
        unique case (a)
            aopc_pkg::OFFS_HI_IDX: rd_mux = offsHi_reg;
            aopc_pkg::OFFS_LO_IDX: rd_mux = offsLo_reg;
            aopc_pkg::FLAG_IDX: rd_mux = flag_reg;
            aopc_pkg::RECAL_IDX: rd_mux = recal_reg;
            aopc_pkg::CKDLY_IDX: rd_mux = ckdly_reg & aopc_pkg::CKDLY_WMASK;
            aopc_pkg::PATA_IDX: rd_mux = pataLo_reg;
            aopc_pkg::PATA_HI_IDX: rd_mux = pataHi_reg;
            aopc_pkg::SRCCFG_IDX: rd_mux = srccfg_reg;
            aopc_pkg::STATUS_IDX: rd_mux = {7'h00, calBusy};
            default: rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    wire logic [9:0] idx = address >> 2;
    // Process form so the mux follows register changes, not only idx
    logic [7:0] rdByte;
    always_comb
    begin
        rdByte = rd_mux(idx);
    end

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            wait_reg <= ~access;
            if (access && read)
                rdata_reg <= {24'h000000, rdByte};
        end
    end

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            offsHi_reg <= aopc_pkg::OFFS_HI_RST;
            offsLo_reg <= 8'h00;
            flag_reg <= aopc_pkg::FLAG_RST;
            recal_reg <= aopc_pkg::RECAL_RST;
            ckdly_reg <= aopc_pkg::CKDLY_RST;
            pataLo_reg <= aopc_pkg::PATA_RST;
            pataHi_reg <= 8'h00;
            srccfg_reg <= aopc_pkg::SRCCFG_RST;
        end
        else if (wrEn)
        begin
            unique case (idx)
                aopc_pkg::OFFS_HI_IDX: offsHi_reg <= wd;
                aopc_pkg::OFFS_LO_IDX: offsLo_reg <= wd;
                aopc_pkg::FLAG_IDX: flag_reg <= wd;
                aopc_pkg::RECAL_IDX: recal_reg <= wd;
                aopc_pkg::CKDLY_IDX: ckdly_reg <= wd & aopc_pkg::CKDLY_WMASK;
                aopc_pkg::PATA_IDX: pataLo_reg <= wd;
                aopc_pkg::PATA_HI_IDX: pataHi_reg <= wd;
                aopc_pkg::SRCCFG_IDX: srccfg_reg <= wd;
                default: ;
            endcase
        end
    end

    // Quarter-LSB offset: drop two fraction bits after signed add
    wire logic signed [17:0] offsFull = $signed({{2{offsHi_reg[7]}}, offsHi_reg, offsLo_reg});
    wire logic signed [17:0] sumQ = $signed({{(18-SAMPLE_W-2){sampleIn[SAMPLE_W-1]}},
        sampleIn, 2'b00}) + offsFull;
    wire logic signed [17:0] maxQ = $signed({{(18-SAMPLE_W-1){1'b0}},
        {(SAMPLE_W-1){1'b1}}, 2'b00});
    wire logic signed [17:0] minQ = -maxQ - 18'sd4;
    wire logic [SAMPLE_W-1:0] clipped = (sumQ > maxQ) ? maxQ[SAMPLE_W+1:2]
        : (sumQ < minQ) ? minQ[SAMPLE_W+1:2] : sumQ[SAMPLE_W+1:2];

    wire logic flagEn = flag_reg[aopc_pkg::FLAG_EN_BIT];
    wire logic flagPol = flag_reg[aopc_pkg::FLAG_POL_BIT];
    // Delay honoured only with synthesiser active and no decimation
    wire logic dlyValid = synthActive & ~srccfg_reg[aopc_pkg::SRC_DEC_BIT];
    wire logic [2:0] dlyCode = ckdly_reg[aopc_pkg::DLY_LSB +: 3];
    // 0..5 map one-to-one is ambiguous; code n gives n cycles, 6->14, 7->15
    wire logic [3:0] dlyCycles = dlyCode[2] & dlyCode[1] ? {3'b111, dlyCode[0]}
        : {1'b0, dlyCode};

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            sample_reg <= '0;
            ovr_reg <= 1'b0;
            wck_reg <= 1'b0;
            coreEn_reg <= 1'b0;
            dly_reg <= 4'h0;
            recalPrev_reg <= 1'b0;
            start_reg <= 1'b0;
            calCnt_reg <= 5'h00;
        end
        else
        begin
            sample_reg <= clipped;
            ovr_reg <= flagEn & (overrangeIn ^ flagPol);
            wck_reg <= flagEn & (wordClockIn ^ flagPol);
            coreEn_reg <= synthActive & ckdly_reg[aopc_pkg::PLLCLK_BIT]
                & synthClkGate;
            dly_reg <= dlyValid ? dlyCycles : 4'h0;
            recalPrev_reg <= recal_reg[aopc_pkg::RECAL_BIT];
            start_reg <= toggled;
            if (toggled)
                calCnt_reg <= 5'(aopc_pkg::CAL_CYCLES);
            else if (calBusy)
                calCnt_reg <= calCnt_reg - 5'h01;
        end
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
    assign sampleOut = sample_reg;
    assign overrange_flag = ovr_reg;
    assign word_clock_marker = wck_reg;
    assign coreClkEnable = coreEn_reg;
    assign outputClockVcoDelay = dly_reg;
    assign recalStart = start_reg;
    // Low nibble of low register is only stored and read back, not part of the pattern
    assign patternA = {pataHi_reg, pataLo_reg[7:4]};
endmodule : aopc_regs

// ---- sim/aopc_regs_props.sv ----
/*
 Checker for the register bank's bus answer and derived outputs.
 Assumes it is bound into aopc_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module aopc_regs_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic overrangeIn,
    input wire logic wordClockIn,
    input wire logic synthClkGate,
    input wire logic overrange_flag,
    input wire logic word_clock_marker,
    input wire logic coreClkEnable,
    input wire logic [3:0] outputClockVcoDelay,
    input wire logic recalStart,
    input wire logic [11:0] patternA
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    sequence s_rd_at(logic [9:0] a);
        read && !waitrequest && address == a;
    endsequence
    a_bus_answer: assert property ((read || write) && waitrequest |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_recal_single: assert property (recalStart |=> !recalStart)
        else $error("recalibration start longer than one cycle");
    a_recal_cause: assert property (recalStart
        |-> $past(write) || $past(write, 2) || $past(write, 3))
        else $error("recalibration start without a write");
    a_flag_pair: assert property (overrangeIn == wordClockIn |=> overrange_flag == word_clock_marker)
        else $error("flag pair treated unequally");
    a_delay_codes: assert property (outputClockVcoDelay <= 4'h5 || outputClockVcoDelay >= 4'hE)
        else $error("clock delay outside coded set");
    a_delay_top_zero: assert property (s_rd_at(10'h1B4) |-> readdata[7:6] == 2'h0)
        else $error("clock delay top bits not zero");
    a_core_gate: assert property (coreClkEnable |-> $past(synthClkGate))
        else $error("core clock enabled without synthesiser clock");
    a_pattern_read: assert property (s_rd_at(10'h1D0) |-> readdata[7:4] == patternA[3:0])
        else $error("pattern nibble differs from output");
endmodule : aopc_regs_props
bind aopc_regs aopc_regs_props i_props (
    .clk(clk),
    .rst_n(rst_n),
    .address(address),
    .read(read),
    .write(write),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .overrangeIn(overrangeIn),
    .wordClockIn(wordClockIn),
    .synthClkGate(synthClkGate),
    .overrange_flag(overrange_flag),
    .word_clock_marker(word_clock_marker),
    .coreClkEnable(coreClkEnable),
    .outputClockVcoDelay(outputClockVcoDelay),
    .recalStart(recalStart),
    .patternA(patternA)
);

// ---- sim/aopc_regs_tb.sv ----
/*
 Self-checking bench for the register bank, driven over Avalon-MM.
 Assumes the checker file is compiled with it and bound to the design.
*/
`timescale 1ns/1ps
module aopc_regs_tb;
    logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic ovrIn = 1'b1, wckIn = 1'b0, gateIn = 1'b1, waitrequest, ovrFlag, wckMark, coreEn, recal;
    logic [9:0] address = 10'h000;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [11:0] sampleIn = 12'h064, sampleOut, patternA;
    logic [3:0] vcoDelay;
    logic [3:0] dly [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hE, 4'hF};
    int failCount = 0, compares = 0, pulses;
    always #25 clk = ~clk;
    aopc_regs i_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .sampleIn(sampleIn), .overrangeIn(ovrIn), .wordClockIn(wckIn), .synthClkGate(gateIn),
        .sampleOut(sampleOut), .overrange_flag(ovrFlag), .word_clock_marker(wckMark),
        .coreClkEnable(coreEn), .outputClockVcoDelay(vcoDelay), .recalStart(recal),
        .patternA(patternA));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Waitrequest and read data taken at the rising edge, before that edge's updates land
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= ~w;
        write <= w;
        writedata <= {24'h0, d};
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : acc
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        acc(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask : rd
    task automatic printVerdict();
        $display("mismatches %0d compares %0d", failCount, compares);
        if (failCount == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : printVerdict
    initial
    begin
        repeat (20000) @(posedge clk);
        failCount++;
        printVerdict();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h67, 32'h00);
        rd(8'h68, 32'h24);
        rd(8'h6B, 32'h08);
        rd(8'h74, 32'h00);
        chk(ovrFlag, 1'b1);
        acc(1'b1, 8'h67, 8'h01);
        repeat (3) @(negedge clk);
        chk(sampleOut, 12'h0A4);
        acc(1'b1, 8'h67, 8'hFF);
        repeat (3) @(negedge clk);
        chk(sampleOut, 12'h024);
        rd(8'h67, 32'hFF);
        wckIn <= 1'b1;
        acc(1'b1, 8'h68, 8'h20);
        repeat (3) @(negedge clk);
        chk({ovrFlag, wckMark}, 2'b00);
        @(posedge clk) ovrIn <= 1'b0;
        acc(1'b1, 8'h68, 8'h2C);
        repeat (3) @(negedge clk);
        chk({ovrFlag, wckMark}, 2'b10);
        for (int i = 0; i < 2; i++)
        begin
            acc(1'b1, 8'h6B, i ? 8'h08 : 8'h0C);
            pulses = 0;
            repeat (8) @(negedge clk) pulses += recal;
            chk(pulses, 1);
            acc(1'b0, 8'hD1, 8'h00);
            chk(q[0], 1'b1);
        end
        repeat (20) @(negedge clk);
        acc(1'b0, 8'hD1, 8'h00);
        chk(q[0], 1'b0);
        acc(1'b1, 8'h6D, 8'h2E);
        repeat (3) @(negedge clk);
        chk({coreEn, vcoDelay}, 5'h00);
        acc(1'b1, 8'hE0, 8'h03);
        for (int c = 0; c < 8; c++)
        begin
            acc(1'b1, 8'h6D, 8'h20 | 8'(c << 1));
            repeat (3) @(negedge clk);
            chk({coreEn, vcoDelay}, {1'b1, dly[c]});
        end
        @(posedge clk) gateIn <= 1'b0;
        repeat (3) @(negedge clk);
        chk(coreEn, 1'b0);
        @(posedge clk) gateIn <= 1'b1;
        acc(1'b1, 8'hE0, 8'h07);
        // Unimplemented top bits written as ones, factory bits kept at zero
        acc(1'b1, 8'h6D, 8'hEE);
        repeat (3) @(negedge clk);
        chk({coreEn, vcoDelay}, 5'h10);
        rd(8'h6D, 32'h2E);
        acc(1'b1, 8'h6D, 8'h0E);
        repeat (3) @(negedge clk);
        chk(coreEn, 1'b0);
        acc(1'b1, 8'h74, 8'hB0);
        acc(1'b1, 8'h75, 8'h3C);
        rd(8'h74, 32'hB0);
        chk(patternA, 12'h3CB);
        acc(1'b1, 8'h10, 8'h5A);
        rd(8'h10, 32'h00);
        printVerdict();
    end
endmodule : aopc_regs_tb
